// File: design/sidd_decoder.sv
/*
 Self-ID packet decoder: takes quadlets from the physical-layer receive path,
 pairs each self-ID quadlet with its inverse and presents the decoded fields.
 Assumes quadlets arrive on clock with a one-cycle strobe from same-domain logic,
 and bus_reset pulses at the start of each self-ID phase.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sidd_map.svh"
module sidd_decoder (
	input  wire logic                 clock,
	input  wire logic                 reset_n,
	input  wire logic                 bus_reset,
	input  wire logic                 quad_valid,
	input  wire logic [31:0]          quad_data,
	output var  sidd_pkg::sidd_result_t result
);
	sidd_pkg::sidd_state_all_t st_ff;
	sidd_pkg::sidd_state_all_t nxt_st;
	logic [31:0] q;
	logic [2:0]  pc;
	logic [3:0]  ew;
	logic [5:0]  sw;
	logic        pair_ok;
	logic        self_pwr;
	logic        bus_pwr;
	logic        spd_rsv;
	logic        dly_ok;
	sidd_pkg::sidd_result_t base_dec;
	sidd_pkg::sidd_result_t ext_dec;

	assign result = st_ff.out;

	always_comb begin
		q = st_ff.quad;
		pc = q[`SIDD_PWR_HI:`SIDD_PWR_LO];
		pair_ok = (quad_data == ~st_ff.quad);
	end

	// Power class decode kept apart so the watt figures sit in one place
	always_comb begin
		sw = 6'h00;
		ew = 4'h0;
		self_pwr = 1'b0;
		bus_pwr = 1'b0;
		case (pc)
			3'h0: begin
				sw = 6'h00;
			end
			3'h1: begin
				sw = 6'h0F;
				self_pwr = 1'b1;
			end
			3'h2: begin
				sw = 6'h1E;
				self_pwr = 1'b1;
			end
			3'h3: begin
				sw = 6'h2D;
				self_pwr = 1'b1;
			end
			3'h4: begin
				bus_pwr = 1'b1;
			end
			3'h5: begin
				bus_pwr = 1'b1;
				ew = 4'h2;
			end
			3'h6: begin
				bus_pwr = 1'b1;
				ew = 4'h5;
			end
			3'h7: begin
				bus_pwr = 1'b1;
				ew = 4'h9;
			end
			default: begin
				sw = 6'h00;
				ew = 4'h0;
			end
		endcase
	end

	always_comb begin
		spd_rsv = 1'b0;
		case (sidd_pkg::sidd_speed_t'(q[`SIDD_SPEED_HI:`SIDD_SPEED_LO]))
			sidd_pkg::SIDD_SPD_S100: spd_rsv = 1'b0;
			sidd_pkg::SIDD_SPD_S200: spd_rsv = 1'b0;
			sidd_pkg::SIDD_SPD_S400: spd_rsv = 1'b0;
			default: spd_rsv = 1'b1;
		endcase
		dly_ok = (q[`SIDD_DELAY_HI:`SIDD_DELAY_LO] == `SIDD_DELAY_144NS);
	end

	// Base packet: every base field is refreshed, ports 0 to 2 sit in the top three slots
	always_comb begin
		base_dec = st_ff.out;
		base_dec.seq = 3'h0;
		base_dec.link_active = q[`SIDD_LINK_BIT];
		base_dec.contender = q[`SIDD_CONT_BIT] && q[`SIDD_LINK_BIT];
		base_dec.gap_count = q[`SIDD_GAP_HI:`SIDD_GAP_LO];
		base_dec.speed = sidd_pkg::sidd_speed_t'(q[`SIDD_SPEED_HI:`SIDD_SPEED_LO]);
		base_dec.delay = q[`SIDD_DELAY_HI:`SIDD_DELAY_LO];
		base_dec.delay_144ns = dly_ok;
		base_dec.power = pc;
		base_dec.self_powered = self_pwr;
		base_dec.bus_powered = bus_pwr;
		base_dec.supply_watts = sw;
		base_dec.extra_watts = ew;
		base_dec.reset_initiator = q[`SIDD_INIT_BIT];
		base_dec.port_base = 5'h00;
		base_dec.port_status = {q[`SIDD_PORT0_HI -: 6], 10'h000};
		base_dec.port_valid = 8'hE0;
		base_dec.format_warn = !dly_ok || spd_rsv;
	end

	// Extended packet: base fields other than seq, node, more, the port fields and format_warn, which is cleared, are left as the last base packet set them
	always_comb begin
		ext_dec = st_ff.out;
		ext_dec.seq = q[`SIDD_SEQ_HI:`SIDD_SEQ_LO];
		ext_dec.format_warn = 1'b0;
		ext_dec.port_base = 5'h00;
		ext_dec.port_status = 16'h0000;
		ext_dec.port_valid = 8'h00;
		case (q[`SIDD_SEQ_HI:`SIDD_SEQ_LO])
			3'h0: begin
				ext_dec.port_base = 5'(`SIDD_BASE_PORTS);
				ext_dec.port_status = q[`SIDD_EPORT_HI -: 16];
				ext_dec.port_valid = 8'hFF;
			end
			3'h1: begin
				ext_dec.port_base = 5'(`SIDD_BASE_PORTS + `SIDD_EXT_PORTS);
				ext_dec.port_status = q[`SIDD_EPORT_HI -: 16];
				ext_dec.port_valid = 8'hFF;
			end
			3'h2: begin
				ext_dec.port_base = 5'(`SIDD_BASE_PORTS + 2 * `SIDD_EXT_PORTS);
				ext_dec.port_status = q[`SIDD_EPORT_HI -: 16];
				ext_dec.port_valid = 8'hFF;
			end
			default: begin
				// Later sequences carry reserved port fields, so no slot is reported valid
				ext_dec.port_valid = 8'h00;
			end
		endcase
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.out.valid = 1'b0;
		nxt_st.out.lost = 1'b0;
		nxt_st.out.corrupt = 1'b0;
		case (st_ff.state)
			sidd_pkg::SIDD_ST_IDLE: begin
				if (quad_valid && quad_data[`SIDD_ID_HI:`SIDD_ID_LO] == `SIDD_ID_SELF) begin
					nxt_st.quad = quad_data;
					nxt_st.state = sidd_pkg::SIDD_ST_INV;
				end
			end
			sidd_pkg::SIDD_ST_INV: begin
				if (quad_valid) begin
					// Reserved bits are never looked at, so nonzero ones raise nothing
					if (q[`SIDD_EXT_BIT]) begin
						nxt_st.out = ext_dec;
					end else begin
						nxt_st.out = base_dec;
					end
					nxt_st.state = sidd_pkg::SIDD_ST_IDLE;
					nxt_st.out.valid = 1'b1;
					nxt_st.out.corrupt = !pair_ok;
					nxt_st.out.node = q[`SIDD_NODE_HI:`SIDD_NODE_LO];
					nxt_st.out.extended = q[`SIDD_EXT_BIT];
					nxt_st.out.more = q[`SIDD_MORE_BIT];
					// Lost check uses the more bit of the last uncorrupted packet, even if this one is corrupt
					nxt_st.out.lost = st_ff.expect_more && (q[`SIDD_NODE_HI:`SIDD_NODE_LO] != st_ff.expect_node);
					if (pair_ok) begin
						nxt_st.expect_more = q[`SIDD_MORE_BIT];
						nxt_st.expect_node = q[`SIDD_NODE_HI:`SIDD_NODE_LO];
					end
				end
			end
			default: nxt_st.state = sidd_pkg::SIDD_ST_IDLE;
		endcase
		// A new bus reset starts a fresh self-ID phase; a waiting pair yields no packet
		if (bus_reset) begin
			nxt_st.state = sidd_pkg::SIDD_ST_IDLE;
			nxt_st.expect_more = 1'b0;
			nxt_st.expect_node = `SIDD_NODE_RST;
			nxt_st.out.valid = 1'b0;
			nxt_st.out.lost = 1'b0;
			nxt_st.out.corrupt = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule
`default_nettype wire

// File: design/sidd_map.svh
/*
 Field positions, codes and counts of the self-ID packet decoder.
 Included by the package and the decoder; bit 31 is the first bit of the quadlet on the wire.
*/
`ifndef SIDD_MAP_SVH
`define SIDD_MAP_SVH
`define SIDD_ID_HI        31
`define SIDD_ID_LO        30
`define SIDD_ID_SELF      2'h2
`define SIDD_NODE_HI      29
`define SIDD_NODE_LO      24
`define SIDD_EXT_BIT      23
`define SIDD_LINK_BIT     22
`define SIDD_GAP_HI       21
`define SIDD_GAP_LO       16
`define SIDD_SPEED_HI     15
`define SIDD_SPEED_LO     14
`define SIDD_DELAY_HI     13
`define SIDD_DELAY_LO     12
`define SIDD_CONT_BIT     11
`define SIDD_PWR_HI       10
`define SIDD_PWR_LO       8
`define SIDD_PORT0_HI     7
`define SIDD_INIT_BIT     1
`define SIDD_MORE_BIT     0
`define SIDD_SEQ_HI       22
`define SIDD_SEQ_LO       20
`define SIDD_EPORT_HI     17
`define SIDD_DELAY_144NS  2'h0
`define SIDD_SPEED_RSV    2'h3
`define SIDD_SEQ_LAST     3'h2
`define SIDD_EXT_PORTS    8
`define SIDD_BASE_PORTS   3
`define SIDD_NODE_RST     6'h00
`endif

// File: design/sidd_pkg.sv
/*
 Types of the self-ID packet decoder.
 Assumes sidd_map.svh is on the include path.
*/
`include "sidd_map.svh"
package sidd_pkg;
	typedef enum logic [1:0] {
		SIDD_PORT_ABSENT = 2'h0,
		SIDD_PORT_OPEN   = 2'h1,
		SIDD_PORT_PARENT = 2'h2,
		SIDD_PORT_CHILD  = 2'h3
	} sidd_port_t;
	typedef enum logic [1:0] {
		SIDD_SPD_S100  = 2'h0,
		SIDD_SPD_S200  = 2'h1,
		SIDD_SPD_S400  = 2'h2,
		SIDD_SPD_RSV   = 2'h3
	} sidd_speed_t;
	typedef enum logic [1:0] {
		SIDD_ST_IDLE   = 2'h0,
		SIDD_ST_INV    = 2'h1
	} sidd_state_t;
	typedef struct packed {
		logic        valid;
		logic        extended;
		logic [2:0]  seq;
		logic [5:0]  node;
		logic        link_active;
		logic        contender;
		logic [5:0]  gap_count;
		sidd_speed_t speed;
		logic [1:0]  delay;
		logic        delay_144ns;
		logic [2:0]  power;
		logic        self_powered;
		logic        bus_powered;
		logic [3:0]  extra_watts;
		logic [5:0]  supply_watts;
		logic        reset_initiator;
		logic        more;
		logic [4:0]  port_base;
		logic [15:0] port_status;
		logic [7:0]  port_valid;
		logic        format_warn;
		logic        corrupt;
		logic        lost;
	} sidd_result_t;
	typedef struct packed {
		sidd_state_t  state;
		logic [31:0]  quad;
		logic         expect_more;
		logic [5:0]   expect_node;
		sidd_result_t out;
	} sidd_state_all_t;
endpackage

// File: test/sidd_assertions.sv
/* Port assertions for the self-ID decoder.
 Bound to sidd_decoder; one clock, async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module sidd_assertions (
	input wire logic                  clock,
	input wire logic                  reset_n,
	input wire logic                  bus_reset,
	input wire logic                  quad_valid,
	input wire logic [31:0]           quad_data,
	input wire sidd_pkg::sidd_result_t result
);
	logic        h_ff;
	logic [31:0] f_ff;
	wire logic   pv = h_ff && quad_valid && !bus_reset;
	// Base field checks skip corrupt packets, whose fields are not trusted, and extended ones
	wire logic   g = result.valid && !result.corrupt && !f_ff[23];
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			h_ff <= 1'h0;
			f_ff <= 32'h0;
		end else if (bus_reset) begin
			h_ff <= 1'h0;
		end else if (quad_valid) begin
			h_ff <= !h_ff && quad_data[31:30] == 2'h2;
			f_ff <= h_ff ? f_ff : quad_data;
		end
	end
	default clocking @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	a_pair_answer:
	assert property (pv |=> result.valid) else $error("no result after pair");
	a_valid_cause:
	assert property (result.valid |-> $past(pv)) else $error("result without pair");
	a_valid_pulse:
	assert property (result.valid |=> !result.valid) else $error("valid too long");
	a_corrupt_flag:
	assert property (result.valid |-> result.corrupt == ($past(quad_data) != ~f_ff)) else $error("corrupt wrong");
	a_node_gap:
	assert property (g |-> {result.node, result.link_active, result.gap_count} == {f_ff[29:24], f_ff[22:16]})
		else $error("base fields wrong");
	a_contender_both:
	assert property (g |-> result.contender == (f_ff[11] && f_ff[22])) else $error("contender wrong");
	a_fmt_warn:
	assert property (g |-> result.format_warn == (f_ff[13:12] != 2'h0 || f_ff[15:14] == 2'h3)
		&& result.delay_144ns == (f_ff[13:12] == 2'h0)) else $error("warning wrong");
	a_power_kind:
	assert property (g |-> result.bus_powered == f_ff[10] && result.self_powered == (f_ff[10:8] inside {3'h1, 3'h2, 3'h3}))
		else $error("power kind wrong");
	a_ext_slot:
	assert property (result.valid && f_ff[23] |-> result.port_valid == (f_ff[22:20] < 3'h3 ? 8'hFF : 8'h00))
		else $error("port slots wrong");
endmodule
bind sidd_decoder sidd_assertions i_chk (.clock(clock), .reset_n(reset_n), .bus_reset(bus_reset),
	.quad_valid(quad_valid), .quad_data(quad_data), .result(result));
`default_nettype wire

// File: test/sidd_phy_model.sv
/* Behavioural physical layer sending self-ID quadlet pairs.
 Started by the bench; changes its lines on the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module sidd_phy_model (
	input wire logic        clock,
	input wire logic        go,
	input wire logic        flip,
	input wire logic [31:0] word,
	output var logic        quad_valid,
	output var logic [31:0] quad_data
);
	logic        ph;
	logic [31:0] w;
	initial begin
		quad_valid = 1'h0;
		quad_data = 32'h0;
		ph = 1'h0;
	end
	always @(negedge clock) begin
		if (ph) begin
			quad_data <= ~w ^ {31'h0, flip};
			ph <= 1'h0;
		end else if (go) begin
			// No link-on packet is ever sent; each word goes out as the bench gives it, link bit included
			quad_data <= word;
			w <= word;
			ph <= 1'h1;
		end else begin
			// Released line: invert the last quadlet each cycle, so an old quadlet reappears every other cycle
			quad_data <= ~quad_data;
		end
		quad_valid <= ph || go;
	end
endmodule
`default_nettype wire

// File: test/tb.sv
/* Self-checking bench for the self-ID decoder.
 Quadlets come from sidd_phy_model; bus_reset is driven here. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic                   clock, reset_n, bus_reset, go, flip, quad_valid;
	logic [31:0]            word, quad_data;
	int                     errors, n_checks;
	sidd_pkg::sidd_result_t result;
	sidd_phy_model i_phy (.clock(clock), .go(go), .flip(flip), .word(word), .quad_valid(quad_valid),
		.quad_data(quad_data));
	sidd_decoder i_dut (.clock(clock), .reset_n(reset_n), .bus_reset(bus_reset), .quad_valid(quad_valid),
		.quad_data(quad_data), .result(result));
	initial begin
		clock = 1'h0;
		forever #2.5 clock = ~clock;
	end
	task report_and_stop;
		if (errors == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task send(input logic [31:0] w, input logic f, input logic ev);
		int k;
		@(posedge clock);
		go <= 1'h1;
		word <= w;
		flip <= f;
		@(posedge clock);
		go <= 1'h0;
		k = 0;
		while (result.valid !== 1'h1 && k < 6) begin
			@(negedge clock);
			k++;
		end
		if (!ev) chk(32'(k), 32'h6);
		else if (k == 6) begin
			errors++;
			report_and_stop;
		end
	endtask
	task t_base;
		for (int p = 0; p < 8; p++) begin
			send(32'h856A_48B6 | (p << 8), 1'h0, 1'h1);
			chk(32'({result.node, result.gap_count, result.link_active, result.contender, result.delay_144ns,
				result.format_warn, result.reset_initiator, result.port_status[15:10], result.port_valid}),
				32'h0B57_6DE0);
			chk(32'({result.speed, result.bus_powered, result.self_powered, result.extra_watts, result.supply_watts}),
				32'({2'h1, 1'(p > 3), 1'(p > 0 && p < 4), 4'(p == 5 ? 2 : p == 6 ? 5 : p == 7 ? 9 : 0),
				6'(p > 0 && p < 4 ? 15 * p : 0)}));
			chk(32'({result.power, result.delay}), 32'(p << 2));
		end
		send(32'h856A_F8B6, 1'h0, 1'h1);
		chk(32'({result.format_warn, result.delay_144ns}), 32'h2);
	endtask
	task t_ext;
		for (int s = 0; s < 4; s++) begin
			send(32'h8181_5554 | (s << 20), 1'h0, 1'h1);
			chk(32'({result.seq, result.port_base, result.port_valid, result.port_status}), {3'(s), 5'(s < 3 ? 3 + 8 * s : 0),
				s < 3 ? 24'hFF_5555 : 24'h0});
			chk(32'({result.extended, result.more}), 32'h2);
		end
	endtask
	task t_lost;
		send(32'h8100_0001, 1'h0, 1'h1);
		send(32'h8200_0000, 1'h0, 1'h1);
		chk(32'(result.lost), 32'h1);
		send(32'h8100_0001, 1'h0, 1'h1);
		bus_reset = 1'h1;
		@(negedge clock);
		bus_reset = 1'h0;
		send(32'h8200_0000, 1'h0, 1'h1);
		chk(32'({result.lost, result.node}), 32'h02);
	endtask
	task t_bad;
		send(32'hC000_0000, 1'h0, 1'h0);
		send(32'h8300_0000, 1'h1, 1'h1);
		chk(32'({result.corrupt, result.node}), 32'h43);
	endtask
	initial begin
		reset_n = 1'h0;
		bus_reset = 1'h0;
		go = 1'h0;
		flip = 1'h0;
		word = 32'h0;
		errors = 0;
		n_checks = 0;
		repeat (16) @(negedge clock);
		reset_n = 1'h1;
		t_base;
		t_ext;
		t_lost;
		t_bad;
		report_and_stop;
	end
endmodule
`default_nettype wire
